/* File: rtl/bridge_ctl_pkg.sv */
// Constants and types for the bridge discard timer and reset control
// Summary of operation
// - Capability head pointer reads fixed 0x80
// - Enabled timer drop sends upstream error message
// - Discard behaviour only in conventional PCI mode
// - Fatal severity only with advanced error reporting
// - Without enable, AER unmasked expiry still messages
// - Drop sets status flag, write one clears
// - Short select picks 2^10, else 2^15
// - Counter starts when completion reaches queue head
// - Expiry drops transaction and sets status
// - Primary discard timer bit reads zero
// - Fast back-to-back enable reads zero, never used
// - Reset bit holds secondary PCI reset asserted
// - Reset bit returns secondary logic to default
// - Reset bit leaves primary and registers intact
package bridge_ctl_pkg;
    localparam logic [11:0] CAP_HEAD_OFFSET = 12'h034;
    localparam logic [11:0] BRIDGE_CTL_OFFSET = 12'h03c;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h100;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h104;
    localparam logic [11:0] MODE_CTL_OFFSET = 12'h108;
    localparam logic [31:0] CAP_HEAD_RESET = 32'h0000_0080;
    localparam logic [15:0] INT_FIELDS_RESET = 16'h00ff;
    localparam int DROP_MSG_EN_BIT = 27;
    localparam int DROP_STAT_BIT = 26;
    localparam int SHORT_SEL_BIT = 25;
    localparam int UPSTREAM_SEL_BIT = 24;
    localparam int FAST_B2B_BIT = 23;
    localparam int SEC_RESET_BIT = 22;
    localparam int LONG_EXP = 15;
    localparam int SHORT_EXP = 10;
    localparam logic [15:0] LONG_COUNT = 16'(1 << LONG_EXP);
    localparam logic [15:0] SHORT_COUNT = 16'(1 << SHORT_EXP);
    localparam logic [1:0] IRQ_DROP_BIT = 2'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        TIMER_IDLE = 3'b001,
        TIMER_RUN = 3'b010,
        TIMER_DROP = 3'b100
    } timer_state_e;

    typedef struct packed {
        logic valid;
        logic fatal;
    } err_msg_s;
endpackage

/* File: rtl/bridge_discard_timer_and_reset_ctl.sv */
// Bridge discard timer, error message, status and secondary reset control
`timescale 1ns/1ps
module bridge_discard_timer_and_reset_ctl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Delayed transaction queue
    input wire logic cplAtHead,
    input wire logic masterRetryDone,
    output logic dropTransaction,
    // Device configuration
    input wire logic secPciMode,
    input wire logic aerPresent,
    input wire logic aerDropMask,
    input wire logic aerDropFatal,
    // Upstream error message
    output bridge_ctl_pkg::err_msg_s errMsg,
    // Secondary bus reset
    output logic pciRst_b,
    output logic secLogicReset,
    output logic fastB2bIssue,
    // Interrupt
    output logic irq
);
    logic rstSync1_reg;
    logic rstSync2_reg;
    logic rstN;
    logic dropMsgEn_reg;
    logic dropStat_reg;
    logic shortSel_reg;
    logic secReset_reg;
    logic [15:0] intFields_reg;
    logic irqStat_reg;
    logic irqMask_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    bridge_ctl_pkg::timer_state_e state_reg;
    bridge_ctl_pkg::timer_state_e state_next;
    logic expire;
    logic wrEn;
    logic w1cDrop;
    logic w1cIrq;
    logic [31:0] ctlWord;

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1_reg <= 1'b0;
            rstSync2_reg <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstSync2_reg <= rstSync1_reg;
        end
    end
    assign rstN = rstSync2_reg;

    // APB handshake, zero wait states
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wrEn = psel && penable && pwrite;
    assign w1cDrop = wrEn && (paddr == bridge_ctl_pkg::BRIDGE_CTL_OFFSET)
        && pwdata[bridge_ctl_pkg::DROP_STAT_BIT];
    assign w1cIrq = wrEn && (paddr == bridge_ctl_pkg::IRQ_STATUS_OFFSET) && pwdata[0];

    // Writable control bits, untouched by secondary reset
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            dropMsgEn_reg <= 1'b0;
            shortSel_reg <= 1'b0;
            secReset_reg <= 1'b0;
            intFields_reg <= bridge_ctl_pkg::INT_FIELDS_RESET;
            irqMask_reg <= 1'b0;
        end else if (wrEn) begin
            if (paddr == bridge_ctl_pkg::BRIDGE_CTL_OFFSET) begin
                dropMsgEn_reg <= pwdata[bridge_ctl_pkg::DROP_MSG_EN_BIT];
                shortSel_reg <= pwdata[bridge_ctl_pkg::SHORT_SEL_BIT];
                secReset_reg <= pwdata[bridge_ctl_pkg::SEC_RESET_BIT];
                intFields_reg <= pwdata[15:0];
            end
            if (paddr == bridge_ctl_pkg::IRQ_MASK_OFFSET) begin
                irqMask_reg <= pwdata[0];
            end
        end
    end

    // Control word readback
    always_comb begin
        ctlWord = bridge_ctl_pkg::WORD_ZERO;
        ctlWord[bridge_ctl_pkg::DROP_MSG_EN_BIT] = dropMsgEn_reg;
        ctlWord[bridge_ctl_pkg::DROP_STAT_BIT] = dropStat_reg;
        ctlWord[bridge_ctl_pkg::SHORT_SEL_BIT] = shortSel_reg;
        ctlWord[bridge_ctl_pkg::UPSTREAM_SEL_BIT] = 1'b0;
        ctlWord[bridge_ctl_pkg::FAST_B2B_BIT] = 1'b0;
        ctlWord[bridge_ctl_pkg::SEC_RESET_BIT] = secReset_reg;
        ctlWord[15:0] = intFields_reg;
    end

    // Read data register
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            prdata <= bridge_ctl_pkg::WORD_ZERO;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                bridge_ctl_pkg::CAP_HEAD_OFFSET: prdata <= bridge_ctl_pkg::CAP_HEAD_RESET;
                bridge_ctl_pkg::BRIDGE_CTL_OFFSET: prdata <= ctlWord;
                bridge_ctl_pkg::IRQ_STATUS_OFFSET: prdata <= {31'h0000_0000, irqStat_reg};
                bridge_ctl_pkg::IRQ_MASK_OFFSET: prdata <= {31'h0000_0000, irqMask_reg};
                bridge_ctl_pkg::MODE_CTL_OFFSET: prdata <= {30'h0000_0000, aerPresent, secPciMode};
                default: prdata <= bridge_ctl_pkg::WORD_ZERO;
            endcase
        end
    end

    // Discard timer state machine
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            bridge_ctl_pkg::TIMER_IDLE: begin
                if (cplAtHead && secPciMode) begin
                    state_next = bridge_ctl_pkg::TIMER_RUN;
                    count_next = shortSel_reg ? bridge_ctl_pkg::SHORT_COUNT
                        : bridge_ctl_pkg::LONG_COUNT;
                end
            end
            bridge_ctl_pkg::TIMER_RUN: begin
                if (masterRetryDone || !secPciMode) begin
                    state_next = bridge_ctl_pkg::TIMER_IDLE;
                end else if (count_reg == 16'h0001) begin
                    state_next = bridge_ctl_pkg::TIMER_DROP;
                end else begin
                    count_next = count_reg - 16'h0001;
                end
            end
            bridge_ctl_pkg::TIMER_DROP: begin
                state_next = bridge_ctl_pkg::TIMER_IDLE;
            end
            default: begin
                state_next = bridge_ctl_pkg::TIMER_IDLE;
            end
        endcase
    end
    assign expire = (state_reg == bridge_ctl_pkg::TIMER_DROP);

    // Timer registers, cleared by secondary reset
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            state_reg <= bridge_ctl_pkg::TIMER_IDLE;
            count_reg <= 16'h0000;
        end else if (secReset_reg) begin
            state_reg <= bridge_ctl_pkg::TIMER_IDLE;
            count_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // Drop status and interrupt status, set beats clear
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            dropStat_reg <= 1'b0;
            irqStat_reg <= 1'b0;
        end else begin
            if (expire) begin
                dropStat_reg <= 1'b1;
            end else if (w1cDrop) begin
                dropStat_reg <= 1'b0;
            end
            if (expire) begin
                irqStat_reg <= 1'b1;
            end else if (w1cIrq) begin
                irqStat_reg <= 1'b0;
            end
        end
    end

    // Upstream error message pulse
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            errMsg <= '0;
        end else begin
            errMsg.valid <= expire && (dropMsgEn_reg || (aerPresent && !aerDropMask));
            errMsg.fatal <= expire && (dropMsgEn_reg || (aerPresent && !aerDropMask))
                && aerPresent && aerDropFatal;
        end
    end

    // Drop pulse, reset pins, interrupt
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            dropTransaction <= 1'b0;
            pciRst_b <= 1'b0;
            secLogicReset <= 1'b1;
            irq <= 1'b0;
        end else begin
            dropTransaction <= expire;
            pciRst_b <= !secReset_reg;
            secLogicReset <= secReset_reg;
            irq <= irqStat_reg && irqMask_reg;
        end
    end
    assign fastB2bIssue = 1'b0;

    // Checks
    stat_set_a: assert property (@(posedge core_clk) disable iff (!rstN)
        expire |=> dropStat_reg) else $error("drop flag not set");
    msg_en_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (expire && dropMsgEn_reg) |=> errMsg.valid) else $error("no message");
    msg_aer_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (expire && aerPresent && !aerDropMask) |=> errMsg.valid) else $error("no aer msg");
    fatal_gate_a: assert property (@(posedge core_clk) disable iff (!rstN)
        errMsg.fatal |-> $past(aerPresent)) else $error("fatal without aer");
    mode_gate_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (state_reg == bridge_ctl_pkg::TIMER_IDLE && !secPciMode) |=>
        state_reg == bridge_ctl_pkg::TIMER_IDLE) else $error("timer outside pci");
    start_load_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (state_reg == bridge_ctl_pkg::TIMER_IDLE && cplAtHead && secPciMode && !secReset_reg
        && shortSel_reg) |=> count_reg == bridge_ctl_pkg::SHORT_COUNT)
        else $error("bad load");
    retry_stop_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (state_reg == bridge_ctl_pkg::TIMER_RUN && masterRetryDone) |=> !expire ##1 !expire)
        else $error("drop after retry");
    rst_pin_a: assert property (@(posedge core_clk) disable iff (!rstN)
        secReset_reg |=> !pciRst_b) else $error("pci reset not held");
    rst_clear_a: assert property (@(posedge core_clk) disable iff (!rstN)
        $rose(secReset_reg) |=> state_reg == bridge_ctl_pkg::TIMER_IDLE ##0 secLogicReset)
        else $error("secondary not reset");
    cfg_keep_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (secReset_reg && !wrEn) |=> $stable(shortSel_reg) && $stable(dropMsgEn_reg))
        else $error("config changed");
    ro_bits_a: assert property (@(posedge core_clk) disable iff (!rstN)
        !ctlWord[bridge_ctl_pkg::UPSTREAM_SEL_BIT] && !ctlWord[bridge_ctl_pkg::FAST_B2B_BIT]
        && !fastB2bIssue) else $error("ro bit set");
endmodule // bridge_discard_timer_and_reset_ctl

/* File: test/pci_master_model.sv */
// Far-side model: delayed completion source and retrying PCI master
`timescale 1ns/1ps
module pci_master_model (
    // Clock
    input wire logic core_clk,
    // Delayed transaction queue
    output logic cplAtHead,
    output logic masterRetryDone
);
    initial begin
        cplAtHead = 1'b0;
        masterRetryDone = 1'b0;
    end
    // Completion reaches queue head, master may retry later
    task automatic deliver(input int retryAfter);
        @(posedge core_clk) cplAtHead <= 1'b1;
        @(posedge core_clk) cplAtHead <= 1'b0;
        if (retryAfter > 0) begin
            repeat (retryAfter) @(posedge core_clk);
            masterRetryDone <= 1'b1;
            @(posedge core_clk) masterRetryDone <= 1'b0;
        end
    endtask
endmodule // pci_master_model

/* File: test/bridge_discard_timer_and_reset_ctl_bench.sv */
// Self-checking bench for the discard timer and secondary reset control
`timescale 1ns/1ps
module bridge_discard_timer_and_reset_ctl_bench;
    localparam logic [11:0] CTL = bridge_ctl_pkg::BRIDGE_CTL_OFFSET;
    localparam logic [11:0] CAP = bridge_ctl_pkg::CAP_HEAD_OFFSET;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic secPciMode = 1'b1, aerPresent = 1'b0, aerDropMask = 1'b0, aerDropFatal = 1'b0;
    logic [31:0] prdata, ctl;
    logic pready, pslverr, cplAtHead, masterRetryDone, dropTransaction;
    logic pciRst_b, secLogicReset, fastB2bIssue, irq, v;
    bridge_ctl_pkg::err_msg_s errMsg;
    logic [31:0] expRd[$];
    logic [31:0] expMsg[$];
    logic [3:0] cfg[5] = '{4'b1001, 4'b1111, 4'b0100, 4'b0110, 4'b0000};
    int miscompares = 0, tests_run = 0, drops = 0, cyc = 0, startCyc = 0, seed = 55699;
    always #25 core_clk = ~core_clk;
    pci_master_model model (.core_clk(core_clk), .cplAtHead(cplAtHead),
        .masterRetryDone(masterRetryDone));
    bridge_discard_timer_and_reset_ctl DUT (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cplAtHead(cplAtHead),
        .masterRetryDone(masterRetryDone), .dropTransaction(dropTransaction),
        .secPciMode(secPciMode), .aerPresent(aerPresent), .aerDropMask(aerDropMask),
        .aerDropFatal(aerDropFatal), .errMsg(errMsg), .pciRst_b(pciRst_b),
        .secLogicReset(secLogicReset), .fastB2bIssue(fastB2bIssue), .irq(irq));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report;
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic hang;
        miscompares++;
        final_report();
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) hang();
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        expRd.push_back(exp);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic waitDrop(input int target);
        for (int n = 0; n < 1200 && drops < target; n++) @(posedge core_clk);
        if (drops < target) hang();
    endtask
    // Watcher: read data and drop pulses against the oldest note
    always @(posedge core_clk) begin
        cyc++;
        if (cplAtHead === 1'b1) startCyc = cyc;
        if (psel && penable && !pwrite && pready === 1'b1 && expRd.size() > 0) begin
            check("prdata", prdata, expRd.pop_front());
            check("fastB2bIssue", 32'(fastB2bIssue), 32'h0000_0000);
        end
        if (dropTransaction !== 1'b0) begin
            drops++;
            check("dropExpected", 32'(expMsg.size()), 32'h0000_0001);
            check("dropTime", 32'(cyc - startCyc > 1023 && cyc - startCyc < 1030), 1);
            if (expMsg.size() > 0)
                check("errMsg", 32'({errMsg.valid, errMsg.valid & errMsg.fatal}),
                    expMsg.pop_front());
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(CAP, 32'h0000_0080);
        apb(1'b1, CAP, 32'hFFFF_FFFF);
        rd(CAP, 32'h0000_0080);
        rd(CTL, 32'h0000_00FF);
        rd(12'h200, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            {aerPresent, aerDropMask, aerDropFatal} <= cfg[i][2:0];
            ctl = {4'h0, cfg[i][3], 3'b011, 8'h80, 16'($random(seed))};
            apb(1'b1, bridge_ctl_pkg::IRQ_MASK_OFFSET, 32'(i % 2));
            apb(1'b1, CTL, ctl);
            rd(CTL, ctl & 32'h0A00_FFFF);
            v = cfg[i][3] | (cfg[i][2] & !cfg[i][1]);
            expMsg.push_back(32'({v, v & cfg[i][2] & cfg[i][0]}));
            model.deliver(0);
            waitDrop(i + 1);
            rd(bridge_ctl_pkg::IRQ_STATUS_OFFSET, 32'h0000_0001);
            check("irq", 32'(irq), 32'(i % 2));
            apb(1'b1, CTL, ctl & 32'h0BFF_FFFF);
            rd(CTL, (ctl & 32'h0A00_FFFF) | 32'h0400_0000);
            apb(1'b1, CTL, ctl | 32'h0400_0000);
            rd(CTL, ctl & 32'h0A00_FFFF);
            apb(1'b1, bridge_ctl_pkg::IRQ_STATUS_OFFSET, 32'h0000_0001);
            repeat (3) @(posedge core_clk);
            check("irqClear", 32'(irq), 32'h0000_0000);
        end
        {aerPresent, aerDropMask, aerDropFatal} <= 3'b000;
        apb(1'b1, CTL, 32'h0200_0000);
        model.deliver(1 + ({$random(seed)} % 900));
        repeat (1100) @(posedge core_clk);
        apb(1'b1, CTL, 32'h0000_0000);
        model.deliver(1500);
        secPciMode <= 1'b0;
        apb(1'b1, CTL, 32'h0A00_0000);
        model.deliver(0);
        repeat (1100) @(posedge core_clk);
        secPciMode <= 1'b1;
        apb(1'b1, CTL, 32'h0240_0000);
        repeat (3) @(posedge core_clk);
        check("pciRst_b", 32'(pciRst_b), 32'h0000_0000);
        check("secLogicReset", 32'(secLogicReset), 32'h0000_0001);
        rd(CTL, 32'h0240_0000);
        model.deliver(0);
        repeat (1100) @(posedge core_clk);
        apb(1'b1, CTL, 32'h0200_0000);
        repeat (3) @(posedge core_clk);
        check("pciRst_b", 32'(pciRst_b), 32'h0000_0001);
        final_report();
    end
endmodule // bridge_discard_timer_and_reset_ctl_bench
